// ---- shared/timer_clock_select_defines.vh ----
// constants for the timer clock and clear select block
`ifndef TIMER_CLOCK_SELECT_DEFINES_VH
`define TIMER_CLOCK_SELECT_DEFINES_VH

// register byte offsets (channel registers: base + channel * stride; status is shared)
`define OFS_TIMER_CONTROL 6'h00
`define OFS_CLOCK_CONTROL 6'h04
`define OFS_COUNT_VALUE 6'h08
`define OFS_COMPARE_A 6'h0C
`define CHANNEL_STRIDE_BIT 4
`define OFS_STATUS 6'h20

// timer_control fields
`define TC_CLEAR_HI 4
`define TC_CLEAR_LO 3
`define TC_SOURCE_HI 2
`define TC_SOURCE_LO 0
`define TC_MASK 8'h1F

// counter_clock_control fields
`define CC_RESET_LEVEL 3
`define CC_EDGE 1
`define CC_DIVISOR 0
`define CC_MASK 8'h0B

// clear modes
`define CLEAR_NONE 2'h0
`define CLEAR_MATCH_A 2'h1
`define CLEAR_EXTERNAL 2'h3

// clock sources
`define SRC_STOP 3'h0
`define SRC_DIV_A 3'h1
`define SRC_DIV_B 3'h2
`define SRC_DIV_C 3'h3
`define SRC_CASCADE 3'h4
`define SRC_EXT_RISE 3'h5
`define SRC_EXT_FALL 3'h6
`define SRC_EXT_BOTH 3'h7

// prescaler taps: tap n toggles at pclk / 2^(n+1)
`define PRESCALE_W 13
`define TAP_DIV2 4'h0
`define TAP_DIV8 4'h2
`define TAP_DIV32 4'h4
`define TAP_DIV64 4'h5
`define TAP_DIV1024 4'h9
`define TAP_DIV8192 4'hC

// reset values
`define COUNT_RESET 8'h00
`define COMPARE_RESET 8'hFF
`define COUNT_ALL_ONES 8'hFF
`define CONTROL_RESET 8'h00
`define FLAGS_RESET 2'h0

`endif

// ---- design/timer_clock_select.v ----
// two-channel 8-bit counter pair with clock source and external clear selection, APB slave
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "timer_clock_select_defines.vh"

module timer_clock_select #(
	parameter ADDR_W = 8
) (
	// apb
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// pins, index is channel
	input wire [1:0] ext_clock,
	input wire [1:0] external_clear_input,
	// status
	output reg [1:0] overflow_q,
	output reg [1:0] match_a_q
);

	////////////////////////////////////////////////////////////////
	wire [7:0] timer_control_q [0:1];
	wire [7:0] counter_clock_control_q [0:1];
	wire [7:0] count_value_q [0:1];
	wire [7:0] compare_a_q [0:1];
	// free-running prescaler shared by both channels
	reg [`PRESCALE_W-1:0] prescale_q;
	wire [`PRESCALE_W-1:0] prescale_d = prescale_q + {{(`PRESCALE_W-1){1'b0}}, 1'b1};
	wire [1:0] inc;
	wire [1:0] ovf_event;
	wire [1:0] match_pulse;
	wire both_cascade;
	wire access = psel & penable & pready;
	wire wr = access & pwrite;
	wire [5:0] addr = paddr[5:0];
	wire high_zero = (paddr[ADDR_W-1:6] == {(ADDR_W-6){1'b0}});
	wire ch_sel = addr[`CHANNEL_STRIDE_BIT];
	wire [5:0] reg_ofs = {2'b00, addr[3:0]};
	wire in_channels = high_zero & (addr[5] == 1'b0);
	wire is_status = high_zero & (addr == `OFS_STATUS);
	wire status_wr = wr & is_status;
	wire [1:0] overflow_d;
	wire [1:0] match_a_d;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_q <= {`PRESCALE_W{1'b0}};
		end else begin
			prescale_q <= prescale_d;
		end
	end

	// mutual cascade has no source: neither channel counts
	assign both_cascade = (timer_control_q[0][`TC_SOURCE_HI:`TC_SOURCE_LO] == `SRC_CASCADE) &&
		(timer_control_q[1][`TC_SOURCE_HI:`TC_SOURCE_LO] == `SRC_CASCADE);

	////////////////////////////////////////////////////////////////
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : chan
			reg [7:0] control_q;
			reg [7:0] clock_control_q;
			reg [7:0] count_q;
			reg [7:0] compare_q;
			reg [2:0] clk_sync_q;
			reg [2:0] clr_sync_q;
			reg match_prev_q;
			reg [3:0] tap;
			reg div_tick;
			reg src_tick;
			wire [2:0] src = timer_control_q[ch][`TC_SOURCE_HI:`TC_SOURCE_LO];
			wire [1:0] clr_mode = timer_control_q[ch][`TC_CLEAR_HI:`TC_CLEAR_LO];
			wire edge_sel = counter_clock_control_q[ch][`CC_EDGE];
			wire div_sel = counter_clock_control_q[ch][`CC_DIVISOR];
			wire tap_now = prescale_q[tap];
			wire tap_next = prescale_d[tap];
			// flop 0 of each chain feeds flop 1 only
			wire ext_rise = clk_sync_q[1] & ~clk_sync_q[2];
			wire ext_fall = ~clk_sync_q[1] & clk_sync_q[2];
			wire clr_rise = clr_sync_q[1] & ~clr_sync_q[2];
			wire is_match = (count_value_q[ch] == compare_a_q[ch]);
			// level or rising edge, chosen per channel
			wire ext_clear = counter_clock_control_q[ch][`CC_RESET_LEVEL] ? clr_sync_q[1] : clr_rise;
			wire do_clear = ((clr_mode == `CLEAR_EXTERNAL) & ext_clear) |
				((clr_mode == `CLEAR_MATCH_A) & is_match);
			// register write strobes for this channel
			wire sel_reg = wr & in_channels & (ch_sel == ch);
			wire count_wr = sel_reg & (reg_ofs == `OFS_COUNT_VALUE);

			// divisor tap from source and divisor select
			always @* begin
				case (src)
					`SRC_DIV_A: tap = div_sel ? `TAP_DIV2 : `TAP_DIV8;
					`SRC_DIV_B: tap = div_sel ? `TAP_DIV32 : `TAP_DIV64;
					`SRC_DIV_C: tap = div_sel ? `TAP_DIV1024 : `TAP_DIV8192;
					default: tap = `TAP_DIV2;
				endcase
				div_tick = edge_sel ? (tap_now & ~tap_next) : (~tap_now & tap_next);
			end

			always @* begin
				case (src)
					`SRC_STOP: src_tick = 1'b0;
					`SRC_DIV_A, `SRC_DIV_B, `SRC_DIV_C: src_tick = div_tick;
					`SRC_CASCADE: src_tick = ~both_cascade & ((ch == 0) ? ovf_event[1] : match_pulse[0]);
					`SRC_EXT_RISE: src_tick = ext_rise;
					`SRC_EXT_FALL: src_tick = ext_fall;
					`SRC_EXT_BOTH: src_tick = ext_rise | ext_fall;
					default: src_tick = 1'b0;
				endcase
			end

			assign inc[ch] = src_tick & ~do_clear & ~count_wr;
			assign ovf_event[ch] = inc[ch] & (count_value_q[ch] == `COUNT_ALL_ONES);
			assign match_pulse[ch] = is_match & ~match_prev_q;
			assign timer_control_q[ch] = control_q;
			assign counter_clock_control_q[ch] = clock_control_q;
			assign count_value_q[ch] = count_q;
			assign compare_a_q[ch] = compare_q;
			// set wins over a software clear
			assign overflow_d[ch] = ovf_event[ch] | (overflow_q[ch] & ~(status_wr & ~pwdata[ch]));
			assign match_a_d[ch] = match_pulse[ch] | (match_a_q[ch] & ~(status_wr & ~pwdata[ch+2]));

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					clk_sync_q <= 3'h0;
					clr_sync_q <= 3'h0;
					match_prev_q <= 1'b0;
					control_q <= `CONTROL_RESET;
					clock_control_q <= `CONTROL_RESET;
					count_q <= `COUNT_RESET;
					compare_q <= `COMPARE_RESET;
				end else begin
					clk_sync_q <= {clk_sync_q[1:0], ext_clock[ch]};
					clr_sync_q <= {clr_sync_q[1:0], external_clear_input[ch]};
					match_prev_q <= is_match;
					if (sel_reg & (reg_ofs == `OFS_TIMER_CONTROL))
						control_q <= pwdata[7:0] & `TC_MASK;
					if (sel_reg & (reg_ofs == `OFS_CLOCK_CONTROL))
						clock_control_q <= pwdata[7:0] & `CC_MASK;
					if (sel_reg & (reg_ofs == `OFS_COMPARE_A))
						compare_q <= pwdata[7:0];
					// software write beats clear, clear beats count
					if (count_wr)
						count_q <= pwdata[7:0];
					else if (do_clear)
						count_q <= `COUNT_RESET;
					else if (inc[ch])
						count_q <= count_q + 8'h01;
				end
			end
		end
	endgenerate

	// sticky flags in one process, one driver per output bit
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_q <= `FLAGS_RESET;
			match_a_q <= `FLAGS_RESET;
		end else begin
			overflow_q <= overflow_d;
			match_a_q <= match_a_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// apb read mux and one wait state
	reg [31:0] rd_data;
	always @* begin
		rd_data = 32'h0000_0000;
		if (is_status)
			rd_data = {28'h000_0000, match_a_q, overflow_q};
		else if (in_channels) begin
			case (reg_ofs)
				`OFS_TIMER_CONTROL: rd_data = {24'h00_0000, timer_control_q[ch_sel]};
				`OFS_CLOCK_CONTROL: rd_data = {24'h00_0000, counter_clock_control_q[ch_sel]};
				`OFS_COUNT_VALUE: rd_data = {24'h00_0000, count_value_q[ch_sel]};
				`OFS_COMPARE_A: rd_data = {24'h00_0000, compare_a_q[ch_sel]};
				default: rd_data = 32'h0000_0000;
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		// pslverr for any address outside 0x00-0x1F and the status register at 0x20
		end else if (psel & penable & ~pready) begin
			pready <= 1'b1;
			pslverr <= ~(is_status | in_channels);
			prdata <= pwrite ? 32'h0000_0000 : rd_data;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule

// ---- tb/timer_clock_select_asserts.sv ----
// port-level assertions for the timer block
`timescale 1ns/1ns
module timer_checks #(
	parameter ADDR_W = 8
) (
	input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata, prdata,
	input wire [1:0] ext_clock, external_clear_input, overflow_q, match_a_q
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire st_wr = psel && penable && pready && pwrite && paddr == 8'h20;
	a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_ready_cause: assert property ($rose(pready) |-> $past(psel && penable)) else $error("pready unasked");
	a_refused_zero: assert property (pslverr |-> pready && prdata == 0) else $error("bad refusal");
	a_unused_zero: assert property (pready && !pwrite && !pslverr && paddr[3:0] == 4'h4 |->
		prdata[7:4] == 4'h0 && !prdata[2]) else $error("unused bits set");
	a_ovf0_sticky: assert property ($fell(overflow_q[0]) |-> $past(st_wr && !pwdata[0]))
		else $error("flag lost");
	a_ovf1_sticky: assert property ($fell(overflow_q[1]) |-> $past(st_wr && !pwdata[1]))
		else $error("flag lost");
	a_match_sticky: assert property ($fell(match_a_q[0]) |-> $past(st_wr && !pwdata[2])) else $error("flag lost");
endmodule
bind timer_clock_select timer_checks #(.ADDR_W(ADDR_W)) timer_checks_inst (.pclk, .presetn, .psel, .penable,
	.pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .ext_clock, .external_clear_input, .overflow_q, .match_a_q);

// ---- tb/pin_model.sv ----
// far-side model of the external count clock and clear pins
`timescale 1ns/1ns
module pin_model (
	input wire pclk,
	output reg [1:0] ext_clock = 2'h0,
	output reg [1:0] external_clear_input = 2'h0
);
	// levels held 3 cycles, above the synchroniser minimum
	task pulse(input ch, input integer n);
		repeat (2 * n) begin
			ext_clock[ch] <= ~ext_clock[ch];
			repeat (3) @(posedge pclk);
		end
	endtask
	task clr(input ch, v);
		begin
			external_clear_input[ch] <= v;
			repeat (5) @(posedge pclk);
		end
	endtask
endmodule

// ---- tb/timer_clock_and_clear_select_bench.sv ----
// self-checking bench for the timer clock and clear select block
`timescale 1ns/1ns
module timer_clock_and_clear_select_bench;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0000_0000, rv;
	wire [31:0] prdata;
	wire pready, pslverr;
	wire [1:0] ext_clock, external_clear_input, overflow_q, match_a_q;
	integer mismatches = 0, checks = 0, i, n;
	integer dv [0:5] = '{8, 2, 64, 32, 8192, 1024};
	always #2 pclk = ~pclk;
	timer_clock_select timer_clock_select_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ext_clock, .external_clear_input, .overflow_q, .match_a_q);
	pin_model pin_model_inst (.pclk, .ext_clock, .external_clear_input);
	////////////////////////////////////////
	task results;
		begin
			$display("checks %0d mismatches %0d", checks, mismatches);
			if (mismatches == 0 && checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task chk(input [8*16-1:0] nm, input [31:0] e, g);
		begin
			checks = checks + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("wrong value %0s (address %h) expected %h seen %h", nm, paddr, e, g);
			end
		end
	endtask
	task acc(input w, input [7:0] a, input [31:0] d);
		begin
			{psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
			@(posedge pclk);
			penable <= 1'h1;
			n = 0;
			do begin
				@(posedge pclk);
				n = n + 1;
			end while (pready !== 1'h1 && n < 20);
			rv = prdata;
			er = pslverr;
			{psel, penable} <= 2'h0;
			if (pready !== 1'h1) begin
				mismatches = mismatches + 1;
				results;
			end
			@(posedge pclk);
		end
	endtask
	task ck(input [7:0] a, input [31:0] e);
		begin
			acc(0, a, 32'h0000_0000);
			chk("read data", e, rv);
		end
	endtask
	////////////////////////////////////////
	task t_regs;
		begin
			ck(8'h04, 8'h00);
			acc(1, 8'h04, 32'h0000_00FF);
			ck(8'h04, 8'h0B);
			ck(8'h24, 8'h00);
			chk("pslverr", 1'h1, er);
		end
	endtask
	task t_div;
		begin
			for (i = 0; i < 6; i = i + 1) begin
				acc(1, 8'h00, 1 + i / 2);
				acc(1, 8'h04, i[0] ? 32'h0000_0003 : 32'h0000_0000);
				acc(1, 8'h08, 32'h0000_0000);
				repeat (8 * dv[i]) @(posedge pclk);
				acc(0, 8'h08, 32'h0000_0000);
				chk("count in range", 1'h1, rv >= 7 && rv <= 10);
			end
			acc(1, 8'h00, 32'h0000_0000);
			acc(1, 8'h08, 32'h0000_0005);
			repeat (40) @(posedge pclk);
			ck(8'h08, 8'h05);
		end
	endtask
	task t_ext;
		begin
			acc(1, 8'h04, 32'h0000_0003);
			for (i = 5; i < 8; i = i + 1) begin
				acc(1, 8'h00, i);
				acc(1, 8'h08, 32'h0000_0000);
				pin_model_inst.pulse(0, 3);
				ck(8'h08, i == 7 ? 6 : 3);
			end
		end
	endtask
	task t_clear;
		begin
			acc(1, 8'h00, 32'h0000_0018);
			acc(1, 8'h04, 32'h0000_0008);
			pin_model_inst.clr(0, 1);
			acc(1, 8'h08, 32'h0000_0040);
			ck(8'h08, 8'h00);
			acc(1, 8'h04, 32'h0000_0000);
			acc(1, 8'h08, 32'h0000_0040);
			ck(8'h08, 8'h40);
			pin_model_inst.clr(0, 0);
			pin_model_inst.clr(0, 1);
			ck(8'h08, 8'h00);
			acc(1, 8'h00, 32'h0000_0000);
			pin_model_inst.clr(0, 0);
			acc(1, 8'h08, 32'h0000_0040);
			pin_model_inst.clr(0, 1);
			ck(8'h08, 8'h40);
		end
	endtask
	task t_casc;
		begin
			acc(1, 8'h10, 32'h0000_0005);
			acc(1, 8'h18, 32'h0000_00FE);
			acc(1, 8'h00, 32'h0000_0004);
			acc(1, 8'h08, 32'h0000_00FF);
			pin_model_inst.pulse(1, 2);
			ck(8'h08, 8'h00);
			chk("overflow_q", 2'h3, overflow_q);
			acc(1, 8'h00, 32'h0000_0005);
			acc(1, 8'h08, 32'h0000_0000);
			acc(1, 8'h0C, 32'h0000_0002);
			acc(1, 8'h10, 32'h0000_0004);
			acc(1, 8'h18, 32'h0000_0000);
			pin_model_inst.pulse(0, 2);
			ck(8'h18, 8'h01);
			chk("match_a_q", 2'h3, match_a_q);
			acc(1, 8'h20, 32'h0000_0000);
			chk("status flags", 4'h0, {overflow_q, match_a_q});
		end
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_regs;
		t_div;
		t_ext;
		t_clear;
		t_casc;
		results;
	end
endmodule
